/* rtl/sspp_defs.vh */
// Purpose: Constants for the synthesizer serial programming front end.
// Assumes: APB data is 32 bits wide and every register takes one aligned word.
// Notes:   Offsets are byte addresses.
`ifndef SSPP_DEFS_VH
`define SSPP_DEFS_VH

// Serial word format.
`define SSPP_WORD_BITS        24
`define SSPP_SEL_MSB          3
`define SSPP_SEL_LSB          0
`define SSPP_PAYLOAD_LSB      4
`define SSPP_MAIN_PAYLOAD_LSB 1
`define SSPP_BITCNT_MAX       5'h1f

// Field positions inside the latched words.
`define SSPP_PD_BIT           23
`define SSPP_AUTOPU_BIT       23
`define SSPP_DITHER_MSB       17
`define SSPP_DITHER_LSB       16
`define SSPP_ORDER_MSB        15
`define SSPP_ORDER_LSB        14

// Latch indices.
`define SSPP_IDX_MAIN_DIV     3'h0
`define SSPP_IDX_MAIN_CFG     3'h1
`define SSPP_IDX_AUX_DIV      3'h2
`define SSPP_IDX_MODE         3'h4

// Modulator order field codes and resulting order.
`define SSPP_FM_FOURTH        2'h0
`define SSPP_FM_THIRD         2'h3
`define SSPP_FM_SECOND        2'h2
`define SSPP_ORDER_FOURTH     3'h4
`define SSPP_ORDER_THIRD      3'h3
`define SSPP_ORDER_SECOND     3'h2
`define SSPP_ORDER_NONE       3'h0

// Dither field codes and the dither mode output.
`define SSPP_DITHER_STRENGTH_OFF         2'h0
`define SSPP_DITHER_STRENGTH_WEAK        2'h1
`define SSPP_DITHER_STRENGTH_STRONG      2'h2

// APB register map.
`define SSPP_ADDR_LATCH_LAST  8'h1c
`define SSPP_ADDR_CTRL        8'h20
`define SSPP_ADDR_STATUS      8'h24
`define SSPP_ADDR_SHIFT       8'h28

// Reset values.
`define SSPP_LATCH_RESET      24'h000000
`define SSPP_CTRL_RESET       1'h1

`endif

/* rtl/sspp_top.v */
// Purpose: Serial programming front end of a dual frequency synthesizer: a
//          three-wire port loads 24-bit words into internal latches, and the
//          power, modulator order and dither controls are decoded from them.
// Assumes: pclk at 100 MHz; serial pins are slower than pclk by a wide margin.
// Notes:   Latches and state are readable over APB; a control bit gates the port.
//
// Decided for this implementation: the register addresses and the APB register port.
`include "sspp_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module sspp_top
(
  input  wire        pclk,                 // System clock, 100 MHz.
  input  wire        presetn,              // Asynchronous reset, active low.
  input  wire        psel,                 // APB select.
  input  wire        penable,              // APB enable.
  input  wire        pwrite,               // APB direction, high for write.
  input  wire [7:0]  paddr,                // APB byte address.
  input  wire [31:0] pwdata,               // APB write data.
  output reg  [31:0] prdata,               // APB read data.
  output reg         pready,               // APB ready.
  output reg         pslverr,              // APB error for unmapped address.
  input  wire        ser_clk,              // Serial clock pin.
  input  wire        ser_data,             // Serial data pin.
  input  wire        latch_strobe,         // Latch strobe pin.
  input  wire        chip_enable,          // Chip power enable pin, high to run.
  output reg         main_powered,         // Main section powered up.
  output reg         aux_powered,          // Auxiliary section powered up.
  output reg  [2:0]  modulator_order,      // Active modulator order, 0 if none.
  output reg  [1:0]  dither_mode,          // 0 off, 1 weak, 2 strong.
  output reg         lock_detect_restart,  // One-cycle pulse on divider write.
  output reg         fastlock_restart      // One-cycle pulse on divider write.
);

  // Pin synchronisers: index 0 clock, 1 data, 2 strobe, 3 enable.
  wire [3:0]  pin_in = {chip_enable, latch_strobe, ser_data, ser_clk};
  wire [3:0]  pin_level;
  wire [3:0]  pin_rise;

  // Each pin keeps its stages in its own generate block so that every flop
  // has a single driver.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_sync
      reg [2:0] stage;
      reg       level;
      reg       level_d;

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          stage   <= 3'h0;
          level   <= 1'b0;
          level_d <= 1'b0;
        end
        else
        begin
          // Stage 0 meets the pin and only stage 1 reads it. A change only
          // counts once the second and third stages agree.
          stage <= {stage[1:0], pin_in[gi]};
          if (stage[1] == stage[2])
            level <= stage[2];
          level_d <= level;
        end
      end

      assign pin_level[gi] = level;
      assign pin_rise[gi]  = level & ~level_d;
    end
  endgenerate

  wire sclk_rise   = pin_rise[0];
  wire sdata_level = pin_level[1];
  wire strobe_rise = pin_rise[2];

  // Control register: bit 0 enables the serial port.
  reg port_enable;

  // Serial shift register and bit counter.
  reg [23:0] shift_word;
  reg [4:0]  bit_count;
  // A strobe edge wins over a clock edge seen in the same cycle, so a host
  // that strobes too soon after its last clock loses that bit, not the load.
  // The counter sticks at its top value instead of wrapping, so a burst that
  // was far too long still reads as too long in the status word.

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_word <= `SSPP_LATCH_RESET;
      bit_count  <= 5'h00;
    end
    else if (port_enable && strobe_rise)
      bit_count <= 5'h00;
    else if (port_enable && sclk_rise)
    begin
      // The earliest bit ends up in bit 23.
      shift_word <= {shift_word[22:0], sdata_level};
      if (bit_count != `SSPP_BITCNT_MAX)
        bit_count <= bit_count + 5'h01;
    end
  end

  // Select decode: bit 0 low means the main divider whatever bits 3..1 hold.
  wire [3:0] sel_bits = shift_word[`SSPP_SEL_MSB:`SSPP_SEL_LSB];
  wire       load_now = port_enable & strobe_rise;
  reg  [2:0] target;

  always @*
  begin
    target = `SSPP_IDX_MAIN_DIV;
    case (sel_bits)
      4'h3:    target = 3'h1;
      4'h5:    target = 3'h2;
      4'h7:    target = 3'h3;
      4'h9:    target = 3'h4;
      4'hb:    target = 3'h5;
      4'hd:    target = 3'h6;
      4'hf:    target = 3'h7;
      default: target = `SSPP_IDX_MAIN_DIV;
    endcase
  end

  // Each latch keeps the whole word; the divider latch owns bits 23..1 and
  // the others bits 23..4 as payload, the rest echoes the select code.
  reg  [23:0] latch_mem [0:7];
  wire        main_div_load = load_now && (target == `SSPP_IDX_MAIN_DIV);

  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_latch
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          latch_mem[gi] <= `SSPP_LATCH_RESET;
        else if (load_now && (target == gi))
          latch_mem[gi] <= shift_word;
      end
    end
  endgenerate

  wire        main_pd_bit  = latch_mem[`SSPP_IDX_MAIN_CFG][`SSPP_PD_BIT];
  wire        aux_pd_bit   = latch_mem[`SSPP_IDX_AUX_DIV][`SSPP_PD_BIT];
  wire        autopu_bit   = latch_mem[`SSPP_IDX_MODE][`SSPP_AUTOPU_BIT];
  wire [1:0]  order_field  = latch_mem[`SSPP_IDX_MODE][`SSPP_ORDER_MSB:`SSPP_ORDER_LSB];
  wire [1:0]  dither_field = latch_mem[`SSPP_IDX_MODE][`SSPP_DITHER_MSB:`SSPP_DITHER_LSB];

  // Divider write restarts lock detect and fastlock timing and bumps the divider load count.
  reg [7:0] main_div_loads;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_detect_restart <= 1'b0;
      fastlock_restart    <= 1'b0;
      main_div_loads      <= 8'h00;
    end
    else
    begin
      lock_detect_restart <= main_div_load;
      fastlock_restart    <= main_div_load;
      if (main_div_load)
        main_div_loads <= main_div_loads + 8'h01;
    end
  end

  // Auto power-up: a divider write with the option set and the synchronised enable pin high overrides the section
  // power-down bits until that section's own latch is written again. The
  // override uses the latch contents before this load, as the word is written
  // in the same edge.
  wire        ce_level   = pin_level[3];
  wire        autopu_hit = main_div_load & autopu_bit & ce_level;
  reg         main_override;
  reg         aux_override;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_override <= 1'b0;
      aux_override  <= 1'b0;
    end
    else
    begin
      if (autopu_hit)
        main_override <= 1'b1;
      else if (load_now && (target == `SSPP_IDX_MAIN_CFG))
        main_override <= 1'b0;
      if (autopu_hit)
        aux_override <= 1'b1;
      else if (load_now && (target == `SSPP_IDX_AUX_DIV))
        aux_override <= 1'b0;
    end
  end

  // The enable pin clears the power flops directly, so power-down does not
  // wait for the synchroniser; power-up waits for the synchronised level.
  // A low glitch shorter than a cycle still drops both sections; the synchronised
  // level never falls, so they come back at the first pclk edge after the pin is high again.
  wire pwr_clr_n = presetn & chip_enable;

  always @(posedge pclk or negedge pwr_clr_n)
  begin
    if (!pwr_clr_n)
    begin
      main_powered <= 1'b0;
      aux_powered  <= 1'b0;
    end
    else
    begin
      main_powered <= ce_level & (~main_pd_bit | main_override);
      aux_powered  <= ce_level & (~aux_pd_bit | aux_override);
    end
  end

  // Modulator order and dither decode; reserved codes fall back to none/off.
  reg [2:0] next_modulator_order;
  reg [1:0] next_dither_mode;

  always @*
  begin
    case (order_field)
      `SSPP_FM_FOURTH: next_modulator_order = `SSPP_ORDER_FOURTH;
      `SSPP_FM_THIRD:  next_modulator_order = `SSPP_ORDER_THIRD;
      `SSPP_FM_SECOND: next_modulator_order = `SSPP_ORDER_SECOND;
      default:         next_modulator_order = `SSPP_ORDER_NONE;
    endcase
    case (dither_field)
      `SSPP_DITHER_STRENGTH_WEAK:   next_dither_mode = `SSPP_DITHER_STRENGTH_WEAK;
      `SSPP_DITHER_STRENGTH_STRONG: next_dither_mode = `SSPP_DITHER_STRENGTH_STRONG;
      default:           next_dither_mode = `SSPP_DITHER_STRENGTH_OFF;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Latches reset to zero, and a zero order code means fourth order.
      modulator_order <= `SSPP_ORDER_FOURTH;
      dither_mode     <= `SSPP_DITHER_STRENGTH_OFF;
    end
    else
    begin
      modulator_order <= next_modulator_order;
      dither_mode     <= next_dither_mode;
    end
  end

  // Register map, one word each:
  //   0x00..0x1c  latches 0..7, read only, the whole 24-bit word as loaded.
  //   0x20        control, bit 0 enables the serial port (reset 1).
  //   0x24        status, read only:
  //                 [0] main section up, [1] aux section up,
  //                 [2] synchronised enable pin,
  //                 [6:4] modulator order, [9:8] dither mode,
  //                 [14:10] bits shifted since the last strobe, stuck at 31,
  //                 [23:16] divider loads since reset, wrapping.
  //   0x28        shift register contents, read only.
  // Writes to read-only words are dropped quietly; other addresses answer
  // with an error, and reads there return zero.

  // APB slave: answer prepared in the setup cycle, so the access phase
  // completes at its first edge.
  wire apb_setup  = psel & ~penable;
  wire apb_write  = psel & penable & pready & pwrite;
  wire is_latch   = (paddr <= `SSPP_ADDR_LATCH_LAST) && (paddr[1:0] == 2'h0);
  wire is_ctrl    = (paddr == `SSPP_ADDR_CTRL);
  wire is_status  = (paddr == `SSPP_ADDR_STATUS);
  wire is_shift   = (paddr == `SSPP_ADDR_SHIFT);
  wire mapped     = is_latch | is_ctrl | is_status | is_shift;

  wire [31:0] status_word = {8'h00, main_div_loads, 1'b0, bit_count,
                             dither_mode, 1'b0, modulator_order,
                             1'b0, ce_level, aux_powered, main_powered};

  // Read data and error fall back to zero outside the access phase, so a
  // master that samples late sees nothing stale.
  reg [31:0] next_prdata;

  always @*
  begin
    next_prdata = 32'h00000000;
    if (is_latch)
      next_prdata = {8'h00, latch_mem[paddr[4:2]]};
    else if (is_ctrl)
      next_prdata = {31'h00000000, port_enable};
    else if (is_status)
      next_prdata = status_word;
    else if (is_shift)
      next_prdata = {8'h00, shift_word};
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata      <= 32'h00000000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      port_enable <= `SSPP_CTRL_RESET;
    end
    else
    begin
      pready <= apb_setup;
      if (apb_setup)
      begin
        prdata  <= pwrite ? 32'h00000000 : next_prdata;
        pslverr <= ~mapped;
      end
      else
      begin
        prdata  <= 32'h00000000;
        pslverr <= 1'b0;
      end
      if (apb_write && is_ctrl)
        port_enable <= pwdata[0];
    end
  end

endmodule // sspp_top

`default_nettype wire

/* tb/sspp_host_model.sv */
// Purpose: Host that loads words over the three-wire serial port.
// Assumes: One serial clock period is 16 pclk cycles, 160 ns.
// Notes:   The serial clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module sspp_host_model (
  input  wire logic pclk,        // Timing reference.
  output var  logic ser_clk,     // Serial clock.
  output var  logic ser_data,    // Serial data.
  output var  logic latch_strobe // Latch strobe.
);
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_strobe = 1'b0;
  end
  task automatic half;
    repeat (8) @(posedge pclk);
  endtask
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--)
    begin
      ser_data <= w[i];
      half();
      ser_clk <= 1'b1;
      half();
      ser_clk <= 1'b0;
    end
    // Released data shows the inverse of its last bit, so a stale sample cannot pass.
    ser_data <= ~w[0];
    half();
    latch_strobe <= 1'b1;
    half();
    half();
    latch_strobe <= 1'b0;
    half();
  endtask
endmodule // sspp_host_model
`default_nettype wire

/* tb/sspp_top_asserts.sv */
// Purpose: Port checks for the serial programming front end.
// Assumes: One pclk domain, reset by presetn.
// Notes:   Bound into every sspp_top instance.
`timescale 1ns/1ps
`default_nettype none
`include "sspp_defs.vh"
module sspp_top_asserts (
  input wire logic        pclk,                // Clock.
  input wire logic        presetn,             // Reset, active low.
  input wire logic        psel,                // Select.
  input wire logic        penable,             // Enable.
  input wire logic [7:0]  paddr,               // Address.
  input wire logic [31:0] prdata,              // Read data.
  input wire logic        pready,              // Ready.
  input wire logic        pslverr,             // Error.
  input wire logic        latch_strobe,        // Strobe pin.
  input wire logic        chip_enable,         // Power enable pin.
  input wire logic        main_powered,        // Main section up.
  input wire logic        aux_powered,         // Aux section up.
  input wire logic        lock_detect_restart, // Lock restart.
  input wire logic        fastlock_restart     // Fastlock restart.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  unmapped_err_a: assert property (pready && paddr > `SSPP_ADDR_SHIFT |->
    pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  ce_off_a: assert property (!chip_enable |-> !main_powered && !aux_powered)
    else $error("powered while enable pin low");
  power_cause_a: assert property ($rose(main_powered) || $rose(aux_powered) |->
    chip_enable && $past(chip_enable, 3)) else $error("power up without enable");
  restart_pair_a: assert property (lock_detect_restart == fastlock_restart)
    else $error("restart pulses differ");
  restart_pulse_a: assert property (lock_detect_restart |=> !lock_detect_restart)
    else $error("restart pulse too long");
  // The strobe pin passes a synchroniser, so the pulse trails its rise by a few cycles.
  restart_cause_a: assert property (lock_detect_restart |->
    $past(latch_strobe, 3) && !$past(latch_strobe, 12)) else $error("restart without strobe");
  cover property (lock_detect_restart);
  cover property (pready && pslverr);
  cover property ($fell(main_powered) && chip_enable);
endmodule // sspp_top_asserts
bind sspp_top sspp_top_asserts u_sspp_top_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .latch_strobe(latch_strobe), .chip_enable(chip_enable),
  .main_powered(main_powered), .aux_powered(aux_powered),
  .lock_detect_restart(lock_detect_restart), .fastlock_restart(fastlock_restart));
`default_nettype wire

/* tb/sspp_top_bench.sv */
// Purpose: Self-checking bench for the serial programming front end.
// Assumes: pclk at 100 MHz; serial words come from the host model.
// Notes:   APB waits are bounded, never assumed.
`timescale 1ns/1ps
`default_nettype none
`include "sspp_defs.vh"
module sspp_top_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        chip_enable = 1'b1;
  wire  [31:0] prdata;
  wire         pready, pslverr, ser_clk, ser_data, latch_strobe, main_powered, aux_powered;
  wire         lock_detect_restart, fastlock_restart;
  wire  [2:0]  modulator_order;
  wire  [1:0]  dither_mode;
  int          n_errors = 0;
  int          checks_done = 0;
  int          n_pulse = 0;
  int          n_fast = 0;
  logic [23:0] exp_latch [8] = '{default: 24'h0};
  logic [3:0]  sels [8] = '{4'h3, 4'h5, 4'h7, 4'h9, 4'hb, 4'hd, 4'h2, 4'he};
  logic [1:0]  fcode [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
  logic [2:0]  ord_exp [4] = '{3'h4, 3'h3, 3'h2, 3'h0};
  logic [23:0] w;
  logic [31:0] d;
  logic        e;
  always #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    if (lock_detect_restart === 1'b1) n_pulse <= n_pulse + 1;
    if (fastlock_restart === 1'b1) n_fast <= n_fast + 1;
  end
  sspp_top u_sspp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe(latch_strobe),
    .chip_enable(chip_enable), .main_powered(main_powered), .aux_powered(aux_powered),
    .modulator_order(modulator_order), .dither_mode(dither_mode),
    .lock_detect_restart(lock_detect_restart), .fastlock_restart(fastlock_restart));
  sspp_host_model u_sspp_host_model (.pclk(pclk), .ser_clk(ser_clk), .ser_data(ser_data),
    .latch_strobe(latch_strobe));
  task automatic check_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++t < 50);
    if (t == 50) n_errors++;
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check_val("rdata", exp, d);
    check_val("pslverr", 32'h0, {31'h0, e});
  endtask
  task automatic pins(input logic m, input logic x);
    check_val("main_powered", {31'h0, m}, {31'h0, main_powered});
    check_val("aux_powered", {31'h0, x}, {31'h0, aux_powered});
  endtask
  task automatic ce(input logic v);
    @(posedge pclk);
    chip_enable <= v;
    #2;
    if (v) repeat (10) @(posedge pclk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    for (int i = 0; i < 8; i++) rd_chk(8'(4 * i), 32'h0);
    rd_chk(`SSPP_ADDR_CTRL, 32'h1);
    pins(1'b1, 1'b1);
    check_val("order", 32'h4, {29'h0, modulator_order});
    apb(1'b1, 8'h2c, 32'hffffffff);
    apb(1'b0, 8'h2c, 32'h0);
    check_val("pslverr", 32'h1, {31'h0, e});
    check_val("rdata", 32'h0, d);
    $display("test reset done");
    foreach (sels[i])
    begin
      w = {4'h0, 4'(i), 12'h3c5, sels[i]};
      load_word: u_sspp_host_model.send(w);
      exp_latch[sels[i][0] ? sels[i][3:1] : 3'h0] = w;
    end
    for (int i = 0; i < 8; i++) rd_chk(8'(4 * i), {8'h0, exp_latch[i]});
    rd_chk(`SSPP_ADDR_SHIFT, {8'h0, w});
    rd_chk(`SSPP_ADDR_STATUS, 32'h00020047);
    check_val("restarts", 32'h2, 32'(n_pulse));
    check_val("fast restarts", 32'h2, 32'(n_fast));
    apb(1'b1, 8'h04, 32'hffffffff);
    check_val("pslverr", 32'h0, {31'h0, e});
    rd_chk(8'h04, {8'h0, exp_latch[1]});
    // With the port gated off, a divider word must neither load nor restart.
    apb(1'b1, `SSPP_ADDR_CTRL, 32'hfffffffe);
    rd_chk(`SSPP_ADDR_CTRL, 32'h0);
    u_sspp_host_model.send(24'hfffff0);
    rd_chk(8'h00, {8'h0, exp_latch[0]});
    apb(1'b1, `SSPP_ADDR_CTRL, 32'h1);
    $display("test decode done");
    for (int i = 0; i < 4; i++)
    begin
      u_sspp_host_model.send({6'h00, 2'(i), fcode[i], 10'h000, 4'h9});
      check_val("order", {29'h0, ord_exp[i]}, {29'h0, modulator_order});
      check_val("dither", (i == 3) ? 32'h0 : 32'(i), {30'h0, dither_mode});
    end
    $display("test modulator done");
    ce(1'b0);
    pins(1'b0, 1'b0);
    u_sspp_host_model.send(24'h800009);
    u_sspp_host_model.send(24'h000000);
    pins(1'b0, 1'b0);
    ce(1'b1);
    pins(1'b1, 1'b1);
    u_sspp_host_model.send(24'h800003);
    pins(1'b0, 1'b1);
    u_sspp_host_model.send(24'h800005);
    pins(1'b0, 1'b0);
    u_sspp_host_model.send(24'h000000);
    pins(1'b1, 1'b1);
    check_val("restarts", 32'h4, 32'(n_pulse));
    check_val("fast restarts", 32'h4, 32'(n_fast));
    $display("test power done");
    report_and_stop();
  end
  initial
  begin
    #300000;
    n_errors++;
    report_and_stop();
  end
endmodule // sspp_top_bench
`default_nettype wire
